// ---- design/haptic_feedback_calibration_regs.sv ----
`timescale 1ns/10ps
`default_nettype none
module haptic_feedback_calibration_regs
    import haptic_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEFAULT_DEV_ADDR
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Serial bus pins
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    // Calibration engine results
    input  wire logic        cal_done,
    input  wire logic [7:0]  cal_bemf_level,
    input  wire logic [1:0]  cal_amp_gain,
    // Settings toward playback engine
    output logic             actuator_type_select,
    output logic [2:0]       brake_gain_ratio,
    output logic [1:0]       loop_gain,
    output logic [1:0]       backemf_amp_gain,
    output logic [7:0]       calibrated_backemf_level,
    // Derived closed-loop values
    output logic [9:0]       drive_fb_gain,
    output logic [14:0]      brake_fb_gain,
    output logic [11:0]      backemf_mv
);

    typedef struct packed {
        logic [7:0]  cal_bemf;
        logic [7:0]  fb_ctrl;
        logic [9:0]  drive;
        logic [14:0] brake;
        logic [11:0] mv;
    } bank_regs_t;

    bank_regs_t  q;
    bank_regs_t  d;
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_data;
    logic [7:0]  rd_addr;
    logic [7:0]  rd_data;
    logic [27:0] mv_prod;

    serial_reg_slave #(
        .DEV_ADDR (DEV_ADDR)
    ) u_slave (
        .clk     (clk),
        .rstn    (rstn),
        .scl_i   (scl_i),
        .sda_i   (sda_i),
        .sda_o   (sda_o),
        .sda_oe  (sda_oe),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .rd_addr (rd_addr),
        .rd_data (rd_data)
    );

    // Ratio multiplier; 7 turns braking off
    function automatic logic [4:0] brake_mult(input logic [2:0] code);
        case (code)
            3'h0:    brake_mult = 5'h01;
            3'h1:    brake_mult = 5'h02;
            3'h2:    brake_mult = 5'h03;
            3'h3:    brake_mult = 5'h04;
            3'h4:    brake_mult = 5'h06;
            3'h5:    brake_mult = 5'h08;
            3'h6:    brake_mult = 5'h10;
            default: brake_mult = 5'h00;
        endcase
    endfunction

    function automatic logic [19:0] mv_coef(input logic [1:0] code);
        case (code)
            2'h0:    mv_coef = MV_COEF_G0;
            2'h1:    mv_coef = MV_COEF_G1;
            2'h2:    mv_coef = MV_COEF_G2;
            default: mv_coef = MV_COEF_G3;
        endcase
    endfunction

    // Unmapped offsets read as zero
    always_comb begin
        case (rd_addr)
            CAL_BEMF_OFFSET: rd_data = q.cal_bemf;
            FB_CTRL_OFFSET:  rd_data = q.fb_ctrl;
            default:         rd_data = UNMAPPED_READ;
        endcase
    end

    always_comb begin
        d = q;
        if (wr_en && wr_addr == CAL_BEMF_OFFSET) begin
            d.cal_bemf = wr_data;
        end
        if (wr_en && wr_addr == FB_CTRL_OFFSET) begin
            d.fb_ctrl = wr_data;
        end
        // calibration overwrite
        // Engine result wins a same-cycle host write: it is newer
        if (cal_done) begin
            d.cal_bemf = cal_bemf_level;
            d.fb_ctrl[AMP_GAIN_LSB +: 2] = cal_amp_gain;
        end
        // gain from level
        // Higher loop gain code scales the level harder
        d.drive = 10'(q.cal_bemf)
                  * (10'(q.fb_ctrl[LOOP_GAIN_LSB +: 2]) + 10'h001);
        d.brake = 15'(q.drive)
                  * 15'(brake_mult(q.fb_ctrl[BRAKE_RATIO_LSB +: 3]));
        // level in millivolts
        // Reciprocal table avoids a divider; LRA gain codes reuse it
        mv_prod = 28'(q.cal_bemf)
                  * 28'(mv_coef(q.fb_ctrl[AMP_GAIN_LSB +: 2]));
        d.mv = mv_prod[MV_FRAC_BITS +: 12];
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            q <= '{cal_bemf: CAL_BEMF_RESET, fb_ctrl: FB_CTRL_RESET,
                   drive: 10'h000, brake: 15'h0000, mv: 12'h000};
        end else begin
            q <= d;
        end
    end

    assign actuator_type_select     = q.fb_ctrl[ACT_TYPE_BIT];
    assign brake_gain_ratio         = q.fb_ctrl[BRAKE_RATIO_LSB +: 3];
    assign loop_gain                = q.fb_ctrl[LOOP_GAIN_LSB +: 2];
    assign backemf_amp_gain         = q.fb_ctrl[AMP_GAIN_LSB +: 2];
    assign calibrated_backemf_level = q.cal_bemf;
    assign drive_fb_gain            = q.drive;
    assign brake_fb_gain            = q.brake;
    assign backemf_mv               = q.mv;

    chk_reset_values: assert property (
        @(posedge clk) $rose(rstn) |->
            calibrated_backemf_level == CAL_BEMF_RESET
            && actuator_type_select == 1'b0 && brake_gain_ratio == 3'h3)
        else $error("reset values wrong");

    chk_host_write: assert property (
        @(posedge clk) disable iff (!rstn)
        wr_en && wr_addr == CAL_BEMF_OFFSET && !cal_done |=>
            calibrated_backemf_level == $past(wr_data))
        else $error("level write lost");

    chk_type_bit: assert property (
        @(posedge clk) disable iff (!rstn)
        wr_en && wr_addr == FB_CTRL_OFFSET |=>
            actuator_type_select == $past(wr_data[7]))
        else $error("actuator type not taken");

    chk_ratio_field: assert property (
        @(posedge clk) disable iff (!rstn)
        wr_en && wr_addr == FB_CTRL_OFFSET |=>
            brake_gain_ratio == $past(wr_data[BRAKE_RATIO_LSB +: 3]))
        else $error("brake ratio not taken");

    chk_loop_field: assert property (
        @(posedge clk) disable iff (!rstn)
        wr_en && wr_addr == FB_CTRL_OFFSET |=>
            loop_gain == $past(wr_data[LOOP_GAIN_LSB +: 2]))
        else $error("loop gain not taken");

    chk_amp_field: assert property (
        @(posedge clk) disable iff (!rstn)
        wr_en && wr_addr == FB_CTRL_OFFSET && !cal_done |=>
            backemf_amp_gain == $past(wr_data[AMP_GAIN_LSB +: 2]))
        else $error("amp gain not taken");

    chk_cal_overwrite: assert property (
        @(posedge clk) disable iff (!rstn)
        cal_done |=> calibrated_backemf_level == $past(cal_bemf_level)
            && backemf_amp_gain == $past(cal_amp_gain))
        else $error("calibration result not stored");

    chk_drive_gain: assert property (
        @(posedge clk) disable iff (!rstn)
        $stable(calibrated_backemf_level) && $stable(loop_gain) |=>
            drive_fb_gain == 10'($past(calibrated_backemf_level))
                * (10'($past(loop_gain)) + 10'h001))
        else $error("drive gain not derived from level");

    chk_brake_off: assert property (
        @(posedge clk) disable iff (!rstn)
        brake_gain_ratio == BRAKE_OFF_CODE ##1
            brake_gain_ratio == BRAKE_OFF_CODE |-> brake_fb_gain == 15'h0000)
        else $error("braking not disabled");

    chk_brake_ratio: assert property (
        @(posedge clk) disable iff (!rstn)
        brake_gain_ratio == 3'h4 |=>
            brake_fb_gain == 15'($past(drive_fb_gain)) * 15'h0006)
        else $error("brake ratio 6x wrong");

    chk_unity_mv: assert property (
        @(posedge clk) disable iff (!rstn)
        calibrated_backemf_level == 8'hFF && backemf_amp_gain == 2'h1
            ##1 $stable(calibrated_backemf_level) && $stable(backemf_amp_gain)
            |-> backemf_mv inside {12'h4C3, 12'h4C4})
        else $error("full scale not 1.22 V");

    cov_host_write:  cover property (@(posedge clk) wr_en);
    cov_cal_done:    cover property (@(posedge clk) cal_done);
    cov_lra_braking: cover property (@(posedge clk)
        actuator_type_select && brake_gain_ratio == BRAKE_OFF_CODE);

endmodule
`default_nettype wire

// ---- inc/haptic_pkg.sv ----
package haptic_pkg;

    // Register offsets
    localparam logic [7:0] CAL_BEMF_OFFSET  = 8'h19;
    localparam logic [7:0] FB_CTRL_OFFSET   = 8'h1A;

    // Values after reset, and the value that unmapped offsets read back
    localparam logic [7:0] CAL_BEMF_RESET   = 8'h6D;
    localparam logic [7:0] FB_CTRL_RESET    = 8'h36;
    localparam logic [7:0] UNMAPPED_READ    = 8'h00;

    // Feedback control field positions
    localparam int ACT_TYPE_BIT             = 7;
    localparam int BRAKE_RATIO_LSB          = 4;
    localparam int LOOP_GAIN_LSB            = 2;
    localparam int AMP_GAIN_LSB             = 0;

    // Brake ratio code that turns braking off
    localparam logic [2:0] BRAKE_OFF_CODE   = 3'h7;

    // Back-EMF full scale and code span
    localparam int BEMF_FULL_SCALE_MV       = 1220;
    localparam int BEMF_CODE_SPAN           = 255;
    localparam int MV_FRAC_BITS             = 16;

    // mV per code scaled by 2^16, one per amplifier gain code
    // (1220 / 255 / gain) * 65536 for gains 0.33, 1.0, 1.8, 4.0
    localparam logic [19:0] MV_COEF_G0      = 20'hE7F78;
    localparam logic [19:0] MV_COEF_G1      = 20'h4C8C9;
    localparam logic [19:0] MV_COEF_G2      = 20'h2A870;
    localparam logic [19:0] MV_COEF_G3      = 20'h13232;

    // Default 7-bit bus address; value is arbitrary
    localparam logic [6:0] DEFAULT_DEV_ADDR = 7'h5A;

    // Serial slave sequencing
    typedef enum {
        SL_IDLE,
        SL_ADDR,
        SL_PTR,
        SL_WDATA,
        SL_RDATA,
        SL_RACK
    } slave_state_t;

endpackage

// ---- design/serial_reg_slave.sv ----
`timescale 1ns/10ps
`default_nettype none
module serial_reg_slave
    import haptic_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEFAULT_DEV_ADDR
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Bus pins
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    // Register side
    output logic            wr_en,
    output logic [7:0]      wr_addr,
    output logic [7:0]      wr_data,
    output logic [7:0]      rd_addr,
    input  wire logic [7:0] rd_data
);

    // Reserved addresses refused at elaboration
    if (DEV_ADDR > 7'h77 || DEV_ADDR < 7'h08) begin : g_bad_addr
        $error("DEV_ADDR lies in a reserved range");
    end

    typedef struct packed {
        logic [2:0]   scl_sync;
        logic [2:0]   sda_sync;
        logic         scl_f;
        logic         sda_f;
        slave_state_t st;
        logic [3:0]   cnt;
        logic [7:0]   sh;
        logic [7:0]   ptr;
        logic         in_ack;
        logic         oe;
        logic         wr;
        logic [7:0]   waddr;
        logic [7:0]   wdata;
    } slave_regs_t;

    slave_regs_t q;
    slave_regs_t d;
    logic        rise;
    logic        fall;
    logic        start;
    logic        stop;

    always_comb begin
        d = q;
        d.wr = 1'b0;
        d.scl_sync = {q.scl_sync[1:0], scl_i};
        d.sda_sync = {q.sda_sync[1:0], sda_i};
        // Level accepted once second and third stage agree
        if (q.scl_sync[1] == q.scl_sync[2]) begin
            d.scl_f = q.scl_sync[2];
        end
        if (q.sda_sync[1] == q.sda_sync[2]) begin
            d.sda_f = q.sda_sync[2];
        end
        rise  = !q.scl_f && d.scl_f;
        fall  = q.scl_f && !d.scl_f;
        start = q.scl_f && d.scl_f && q.sda_f && !d.sda_f;
        stop  = q.scl_f && d.scl_f && !q.sda_f && d.sda_f;
        if (start) begin
            d.st = SL_ADDR;
            d.cnt = 4'h0;
            d.oe = 1'b0;
            d.in_ack = 1'b0;
        end else if (stop) begin
            d.st = SL_IDLE;
            d.oe = 1'b0;
            d.in_ack = 1'b0;
        end else begin
            case (q.st)
                SL_ADDR, SL_PTR, SL_WDATA: begin
                    if (rise && !q.in_ack) begin
                        d.sh = {q.sh[6:0], d.sda_f};
                        d.cnt = q.cnt + 4'h1;
                    end else if (fall && q.in_ack) begin
                        d.oe = 1'b0;
                        d.in_ack = 1'b0;
                        d.cnt = 4'h0;
                    end else if (fall && q.cnt == 4'h8) begin
                        d.oe = 1'b1;
                        d.in_ack = 1'b1;
                        if (q.st == SL_ADDR) begin
                            if (q.sh[7:1] != DEV_ADDR) begin
                                d.oe = 1'b0;
                                d.in_ack = 1'b0;
                                d.st = SL_IDLE;
                            end else if (q.sh[0]) begin
                                d.st = SL_RDATA;
                            end else begin
                                d.st = SL_PTR;
                            end
                        end else if (q.st == SL_PTR) begin
                            d.ptr = q.sh;
                            d.st = SL_WDATA;
                        end else begin
                            d.wr = 1'b1;
                            d.waddr = q.ptr;
                            d.wdata = q.sh;
                            d.ptr = q.ptr + 8'h01;
                        end
                    end
                end
                SL_RDATA: begin
                    if (fall && q.in_ack) begin
                        // Ack release and first data bit share one edge
                        d.sh = rd_data;
                        d.oe = !rd_data[7];
                        d.in_ack = 1'b0;
                        d.cnt = 4'h0;
                    end else if (rise) begin
                        d.cnt = q.cnt + 4'h1;
                    end else if (fall && q.cnt == 4'h8) begin
                        d.oe = 1'b0;
                        d.st = SL_RACK;
                    end else if (fall) begin
                        d.sh = {q.sh[6:0], 1'b0};
                        d.oe = !q.sh[6];
                    end
                end
                SL_RACK: begin
                    if (rise) begin
                        if (d.sda_f) begin
                            d.st = SL_IDLE;
                        end else begin
                            d.st = SL_RDATA;
                            d.in_ack = 1'b1;
                            d.ptr = q.ptr + 8'h01;
                        end
                    end
                end
                SL_IDLE: begin
                end
                default: begin
                    d.st = SL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            q <= '{scl_sync: 3'h7, sda_sync: 3'h7, scl_f: 1'b1,
                   sda_f: 1'b1, st: SL_IDLE, cnt: 4'h0, sh: 8'h00,
                   ptr: 8'h00, in_ack: 1'b0, oe: 1'b0, wr: 1'b0,
                   waddr: 8'h00, wdata: 8'h00};
        end else begin
            q <= d;
        end
    end

    // Open drain: only ever pulls low
    assign sda_o   = 1'b0;
    assign sda_oe  = q.oe;
    assign wr_en   = q.wr;
    assign wr_addr = q.waddr;
    assign wr_data = q.wdata;
    assign rd_addr = q.ptr;

endmodule
`default_nettype wire

// ---- dv/i2c_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model #(
    parameter int HALF = 10
) (
    // Clock
    input  wire logic clk,
    // Bus wires
    input  wire logic sda_line,
    output logic      scl_o,
    output logic      sda_low
);
    initial begin
        scl_o   = 1'b1;
        sda_low = 1'b0;
    end

    task automatic wt();
        repeat (HALF) @(posedge clk);
    endtask

    // Works as repeated start too, entered with SCL low
    task automatic start();
        sda_low <= 1'b0;
        wt();
        scl_o <= 1'b1;
        wt();
        sda_low <= 1'b1;
        wt();
        scl_o <= 1'b0;
        wt();
    endtask

    task automatic stop();
        sda_low <= 1'b1;
        wt();
        scl_o <= 1'b1;
        wt();
        sda_low <= 1'b0;
        wt();
    endtask

    // SDA held a full half period past the SCL fall
    task automatic bit_io(input logic b, output logic r);
        sda_low <= ~b;
        wt();
        scl_o <= 1'b1;
        wt();
        r = sda_line;
        scl_o <= 1'b0;
        wt();
    endtask

    task automatic xfer(input logic [7:0] tx, input logic host_ack,
                        output logic [7:0] rx, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], r);
            rx[i] = r;
        end
        bit_io(~host_ack, r);
        ack = ~r;
    endtask

    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                             input logic [7:0] data, output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2;
        start();
        xfer({dev, 1'b0}, 1'b0, rx, a0);
        xfer(ptr, 1'b0, rx, a1);
        xfer(data, 1'b0, rx, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask

    // Two bytes: ACK after the first, NACK after the second
    task automatic read_pair(input logic [6:0] dev, input logic [7:0] ptr,
                             output logic [7:0] d0, output logic [7:0] d1,
                             output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2, a3;
        start();
        xfer({dev, 1'b0}, 1'b0, rx, a0);
        xfer(ptr, 1'b0, rx, a1);
        start();
        xfer({dev, 1'b1}, 1'b0, rx, a2);
        xfer(8'hFF, 1'b1, d0, a3);
        xfer(8'hFF, 1'b0, d1, a3);
        stop();
        ok = a0 & a1 & a2;
    endtask
endmodule
`default_nettype wire

// ---- dv/haptic_feedback_calibration_regs_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
        fail_count++; \
        $display("FAIL %0t: got %0h expected %0h", $time, got, exp); \
    end \
end
module haptic_feedback_calibration_regs_tb;
    import haptic_pkg::*;
    logic        clk;
    logic        rstn;
    logic        scl;
    logic        host_low;
    logic        sda_o;
    logic        sda_oe;
    logic        cal_done;
    logic [7:0]  cal_level;
    logic [1:0]  cal_gain;
    logic        act;
    logic [2:0]  brake;
    logic [1:0]  loopg;
    logic [1:0]  ampg;
    logic [7:0]  level;
    logic [9:0]  drive;
    logic [14:0] brake_fb;
    logic [11:0] mv;
    logic [7:0]  d0;
    logic [7:0]  d1;
    logic [7:0]  ctl;
    logic        ok;
    int          fail_count;
    int          n_compared;
    int          mult [8] = '{1, 2, 3, 4, 6, 8, 16, 0};
    wire logic   sda_line = (sda_oe ? sda_o : 1'b1) & ~host_low;

    haptic_feedback_calibration_regs u_dut (
        .clk(clk), .rstn(rstn), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .cal_done(cal_done),
        .cal_bemf_level(cal_level), .cal_amp_gain(cal_gain),
        .actuator_type_select(act), .brake_gain_ratio(brake),
        .loop_gain(loopg), .backemf_amp_gain(ampg),
        .calibrated_backemf_level(level), .drive_fb_gain(drive),
        .brake_fb_gain(brake_fb), .backemf_mv(mv)
    );

    i2c_host_model u_host (
        .clk(clk), .sda_line(sda_line), .scl_o(scl), .sda_low(host_low)
    );

    always #20 clk = ~clk;

    task automatic check_out(input logic [7:0] lvl, input logic [7:0] c);
        logic [9:0]  drv;
        logic [19:0] coef;
        drv  = 10'(32'(lvl) * (32'(c[3:2]) + 1));
        coef = (c[1:0] == 2'h0) ? MV_COEF_G0 : (c[1:0] == 2'h1) ? MV_COEF_G1
             : (c[1:0] == 2'h2) ? MV_COEF_G2 : MV_COEF_G3;
        `CHK(level, lvl)
        `CHK(act, c[7])
        `CHK(brake, c[6:4])
        `CHK(loopg, c[3:2])
        `CHK(ampg, c[1:0])
        `CHK(drive, drv)
        `CHK(brake_fb, 15'(32'(drv) * mult[c[6:4]]))
        `CHK(mv, 12'((40'(lvl) * 40'(coef)) >> 16))
    endtask

    task automatic results();
        if (fail_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Writes take about 880 clocks, reads about 1460; generous margin
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        $display("FAIL %0t: watchdog expired", $time);
        results();
    end

    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        cal_done = 1'b0;
        cal_level = 8'h00;
        cal_gain = 2'h0;
        fail_count = 0;
        n_compared = 0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        u_host.read_pair(DEFAULT_DEV_ADDR, CAL_BEMF_OFFSET, d0, d1, ok);
        `CHK(ok, 1'b1)
        `CHK(d0, 8'h6D)
        `CHK(d1, 8'h36)
        check_out(8'h6D, 8'h36);
        u_host.write_reg(DEFAULT_DEV_ADDR, CAL_BEMF_OFFSET, 8'hFF, ok);
        `CHK(ok, 1'b1)
        for (int i = 0; i < 8; i++) begin
            ctl = {i[0], i[2:0], i[1:0], ~i[1:0]};
            u_host.write_reg(DEFAULT_DEV_ADDR, FB_CTRL_OFFSET, ctl, ok);
            `CHK(ok, 1'b1)
            check_out(8'hFF, ctl);
        end
        // Type and brake ratio set ahead of calibration
        ctl = 8'hA7;
        u_host.write_reg(DEFAULT_DEV_ADDR, FB_CTRL_OFFSET, ctl, ok);
        @(posedge clk);
        cal_done <= 1'b1;
        cal_level <= 8'h11;
        cal_gain <= 2'h2;
        @(posedge clk);
        cal_level <= 8'h42;
        cal_gain <= 2'h0;
        @(posedge clk);
        cal_done <= 1'b0;
        cal_level <= 8'h99;
        cal_gain <= 2'h3;
        repeat (4) @(posedge clk);
        check_out(8'h42, 8'hA4);
        u_host.read_pair(DEFAULT_DEV_ADDR, 8'h18, d0, d1, ok);
        `CHK(d0, UNMAPPED_READ)
        `CHK(d1, 8'h42)
        u_host.write_reg(DEFAULT_DEV_ADDR, 8'h1B, 8'h55, ok);
        `CHK(ok, 1'b1)
        u_host.read_pair(DEFAULT_DEV_ADDR, FB_CTRL_OFFSET, d0, d1, ok);
        `CHK(d0, 8'hA4)
        `CHK(d1, UNMAPPED_READ)
        u_host.write_reg(DEFAULT_DEV_ADDR ^ 7'h01, FB_CTRL_OFFSET,
                         8'h00, ok);
        `CHK(ok, 1'b0)
        check_out(8'h42, 8'hA4);
        results();
    end
endmodule
`undef CHK
`default_nettype wire
